// [src/drml_top.sv]
/*
 Lock detector, loop bandwidth and slope control, and four
 reference monitors behind an AXI4-Lite slave.
 Assumes ref_in pins are asynchronous and phase_err_mag comes
 from the phase detector on clk.
*/
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "drml_params.svh"
module drml_top #(
   parameter int LOCK_CYC = `DRML_LOCK_US * `DRML_CLK_MHZ
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  ref_in,
   input  wire logic [15:0] phase_err_mag,
   input  wire logic        ref_switch,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             locked,
   output logic [3:0]       corner_freq_select,
   output logic [15:0]      slope_limit_setting,
   output logic             slope_limiter_bypass,
   output logic             semi_fast_lock_enable,
   output logic             phase_realign_request,
   output logic             phase_hold,
   output logic [3:0]       ref_fail
);
   drml_pkg::drml_state_s q;
   drml_pkg::drml_state_s next_q;
   logic [3:0]  rise;
   logic [2:0]  fr;
   logic [15:0] sp_max;
   logic [15:0] sp_min;
   logic [31:0] mp_cnt;
   logic [31:0] fu;
   logic [31:0] nu;
   logic [31:0] nl;
   logic [31:0] fl;
   logic [31:0] acc;
   logic [16:0] su;
   logic [2:0]  zone;
   logic [5:0]  ri;
   logic [5:0]  base;
   logic [15:0] rdv;
   logic [15:0] ctrl;
   logic [15:0] bw;
   logic [15:0] mask;

   // Built-in single-period window, 10 ns units
   function automatic logic [15:0] def_max(input logic [2:0] f);
      unique case (f)
         drml_pkg::FR_8K:  def_max = `DRML_SPMAX_8K;
         drml_pkg::FR_T1:  def_max = `DRML_SPMAX_T1;
         drml_pkg::FR_E1:  def_max = `DRML_SPMAX_E1;
         drml_pkg::FR_4M:  def_max = `DRML_SPMAX_4M;
         drml_pkg::FR_8M:  def_max = `DRML_SPMAX_8M;
         drml_pkg::FR_16M: def_max = `DRML_SPMAX_16M;
         default:          def_max = `DRML_SPMAX_19M;
      endcase
   endfunction

   function automatic logic [15:0] def_min(input logic [2:0] f);
      unique case (f)
         drml_pkg::FR_8K:  def_min = `DRML_SPMIN_8K;
         drml_pkg::FR_T1:  def_min = `DRML_SPMIN_T1;
         drml_pkg::FR_E1:  def_min = `DRML_SPMIN_E1;
         drml_pkg::FR_4M:  def_min = `DRML_SPMIN_4M;
         drml_pkg::FR_8M:  def_min = `DRML_SPMIN_8M;
         default:          def_min = `DRML_SPMIN_FAST;
      endcase
   endfunction

   // Ten seconds of reference cycles per rate
   function automatic logic [31:0] def_cnt(input logic [2:0] f);
      unique case (f)
         drml_pkg::FR_8K:  def_cnt = `DRML_CNT_8K;
         drml_pkg::FR_T1:  def_cnt = `DRML_CNT_T1;
         drml_pkg::FR_E1:  def_cnt = `DRML_CNT_E1;
         drml_pkg::FR_4M:  def_cnt = `DRML_CNT_4M;
         drml_pkg::FR_8M:  def_cnt = `DRML_CNT_8M;
         drml_pkg::FR_16M: def_cnt = `DRML_CNT_16M;
         default:          def_cnt = `DRML_CNT_19M;
      endcase
   endfunction

   // 16 and 19.44 MHz alias at this clock rate
   function automatic logic [2:0] detect(input logic [15:0] c);
      if (c >= `DRML_DET_8K) begin
         detect = drml_pkg::FR_8K;
      end else if (c >= `DRML_DET_T1) begin
         detect = drml_pkg::FR_T1;
      end else if (c >= `DRML_DET_E1) begin
         detect = drml_pkg::FR_E1;
      end else if (c >= `DRML_DET_4M) begin
         detect = drml_pkg::FR_4M;
      end else if (c >= `DRML_DET_8M) begin
         detect = drml_pkg::FR_8M;
      end else if (c >= `DRML_DET_16M) begin
         detect = drml_pkg::FR_16M;
      end else begin
         detect = drml_pkg::FR_19M;
      end
   endfunction

   function automatic drml_pkg::drml_state_s rst_val();
      drml_pkg::drml_state_s s;
      s = '0;
      s.regs[`DRML_I_BW][3:0] = `DRML_BW_DEF;
      s.regs[`DRML_I_SLOPE]   = `DRML_SLOPE_DEF;
      s.regs[`DRML_I_LTHR]    = `DRML_LTHR_DEF;
      s.regs[`DRML_I_LINT]    = `DRML_LINT_DEF;
      {s.regs[`DRML_I_NUL+6'h1], s.regs[`DRML_I_NUL]} = `DRML_MP_NU;
      {s.regs[`DRML_I_FUL+6'h1], s.regs[`DRML_I_FUL]} = `DRML_MP_FU;
      {s.regs[`DRML_I_NLL+6'h1], s.regs[`DRML_I_NLL]} = `DRML_MP_NL;
      {s.regs[`DRML_I_FLL+6'h1], s.regs[`DRML_I_FLL]} = `DRML_MP_FL;
      for (int i = 0; i < 4; i++) begin
         s.regs[`DRML_I_REF0+6'(4*i)]   = def_max(drml_pkg::FR_8K);
         s.regs[`DRML_I_REF0+6'(4*i+1)] = def_min(drml_pkg::FR_8K);
         {s.regs[`DRML_I_REF0+6'(4*i+3)], s.regs[`DRML_I_REF0+6'(4*i+2)]} = `DRML_CNT_8K;
         s.mp_prev[i] = drml_pkg::ZN_GREY;
      end
      s.awr = 1'b1;
      s.wr  = 1'b1;
      s.arr = 1'b1;
      s.corner = `DRML_BW_DEF;
      s.slope  = `DRML_SLOPE_DEF;
      return s;
   endfunction

   always_comb begin
      next_q = q;
      rise   = q.s2 & ~q.s3;
      ctrl   = q.regs[`DRML_I_CTRL];
      bw     = q.regs[`DRML_I_BW];
      mask   = q.regs[`DRML_I_MASK];
      fr     = '0;
      sp_max = '0;
      sp_min = '0;
      mp_cnt = '0;
      acc    = '0;
      su     = '0;
      zone   = drml_pkg::ZN_GREY;
      base   = '0;
      rdv    = '0;
      ri     = s_axi_araddr[7:2];
      // Only s2 and s3 read the pin copies
      next_q.s1 = ref_in;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      // Hysteresis limits shared by all monitors
      if (ctrl[`DRML_B_PROG]) begin
         fu = {q.regs[`DRML_I_FUL+6'h1], q.regs[`DRML_I_FUL]};
         nu = {q.regs[`DRML_I_NUL+6'h1], q.regs[`DRML_I_NUL]};
         nl = {q.regs[`DRML_I_NLL+6'h1], q.regs[`DRML_I_NLL]};
         fl = {q.regs[`DRML_I_FLL+6'h1], q.regs[`DRML_I_FLL]};
      end else begin
         fu = `DRML_MP_FU;
         nu = `DRML_MP_NU;
         nl = `DRML_MP_NL;
         fl = `DRML_MP_FL;
      end

      // Write side: address and data in either order
      if (s_axi_awvalid && q.awr) begin
         next_q.awh  = 1'b1;
         next_q.awa  = s_axi_awaddr[7:2];
         next_q.awok = s_axi_awaddr[7:2] < `DRML_N_REG;
      end
      if (s_axi_wvalid && q.wr) begin
         next_q.wh = 1'b1;
         next_q.wd = s_axi_wdata[15:0];
         next_q.ws = s_axi_wstrb[1:0];
      end
      next_q.realign = 1'b0;
      if (q.awh && q.wh && !q.bv) begin
         next_q.awh   = 1'b0;
         next_q.wh    = 1'b0;
         next_q.bv    = 1'b1;
         next_q.bresp = q.awok ? 2'h0 : 2'h3;
         // Status words are computed, not stored
         if (q.awok && q.awa != `DRML_I_RCS && q.awa != `DRML_I_MSTAT) begin
            if (q.ws[0]) begin
               next_q.regs[q.awa][7:0] = q.wd[7:0];
            end
            if (q.ws[1]) begin
               next_q.regs[q.awa][15:8] = q.wd[15:8];
            end
            if (q.awa == `DRML_I_RCC) begin
               next_q.realign = q.ws[0] & q.wd[`DRML_B_REAL];
               next_q.regs[`DRML_I_RCC][`DRML_B_REAL] = 1'b0;
            end
         end
      end
      if (q.bv && s_axi_bready) begin
         next_q.bv = 1'b0;
      end
      next_q.awr = !next_q.awh && !next_q.bv;
      next_q.wr  = !next_q.wh && !next_q.bv;

      // Read side
      if (q.rv && s_axi_rready) begin
         next_q.rv  = 1'b0;
         next_q.arr = 1'b1;
      end
      if (s_axi_arvalid && q.arr) begin
         if (ri == `DRML_I_RCS) begin
            rdv = {15'h0, q.locked};
         end else if (ri == `DRML_I_MSTAT) begin
            rdv = {4'h0, q.fail, q.mp_fail & ~mask[7:4], q.sp_fail & ~mask[3:0]};
         end else if (ri < `DRML_N_REG) begin
            rdv = q.regs[ri];
         end
         next_q.rv    = 1'b1;
         next_q.arr   = 1'b0;
         next_q.rd    = rdv;
         next_q.rresp = (ri < `DRML_N_REG) ? 2'h0 : 2'h3;
      end

      // Reference monitors, one per input
      for (int i = 0; i < 4; i++) begin
         base = `DRML_I_REF0 + 6'(4*i);
         fr = ctrl[`DRML_B_OVR] ? q.regs[`DRML_I_FREQ][3*i+:3] : q.det[i];
         if (ctrl[`DRML_B_PROG]) begin
            sp_max = q.regs[base];
            sp_min = q.regs[base+6'h1];
            mp_cnt = {q.regs[base+6'h3], q.regs[base+6'h2]};
         end else begin
            sp_max = def_max(fr);
            sp_min = def_min(fr);
            mp_cnt = def_cnt(fr);
         end
         // Single period, counted in 10 ns units
         su = {q.sp_cnt[i], 1'b0};
         if (rise[i]) begin
            next_q.sp_fail[i] = su < {1'b0, sp_min} || su > {1'b0, sp_max};
            next_q.det[i]     = detect(q.sp_cnt[i]);
            next_q.sp_cnt[i]  = 16'h1;
         end else begin
            if (q.sp_cnt[i] != 16'hFFFF) begin
               next_q.sp_cnt[i] = q.sp_cnt[i] + 16'h1;
            end
            // Early loss: period already too long
            if (su > {1'b0, sp_max}) begin
               next_q.sp_fail[i] = 1'b1;
            end
         end
         // Multi period over the programmed cycle count
         acc = q.mp_acc[i] + `DRML_UNIT_STEP;
         next_q.mp_acc[i] = acc;
         if (rise[i]) begin
            next_q.mp_edges[i] = q.mp_edges[i] + 32'h1;
         end
         if ((rise[i] && q.mp_edges[i] + 32'h1 >= mp_cnt) || acc > fl) begin
            if (acc < fu || acc > fl) begin
               zone = drml_pkg::ZN_BAD;
            end else if (acc >= nu && acc <= nl) begin
               zone = drml_pkg::ZN_GOOD;
            end else begin
               zone = drml_pkg::ZN_GREY;
            end
            // Grey zone keeps the previous verdict
            if (zone == q.mp_prev[i] && zone != drml_pkg::ZN_GREY) begin
               next_q.mp_fail[i] = zone == drml_pkg::ZN_BAD;
            end
            next_q.mp_prev[i]  = zone;
            next_q.mp_edges[i] = '0;
            next_q.mp_acc[i]   = '0;
         end
      end
      next_q.fail = (q.sp_fail & ~mask[3:0]) | (q.mp_fail & ~mask[7:4]);

      // Lock detector
      if (phase_err_mag >= q.regs[`DRML_I_LTHR]) begin
         next_q.li_bad = 1'b1;
      end
      next_q.li_cnt = q.li_cnt + 32'h1;
      if (q.li_cnt == 32'(LOCK_CYC - 1)) begin
         next_q.li_cnt = '0;
         next_q.li_bad = 1'b0;
         if (q.li_bad || phase_err_mag >= q.regs[`DRML_I_LTHR]) begin
            next_q.good_cnt = '0;
         end else if (q.good_cnt != 16'hFFFF) begin
            next_q.good_cnt = q.good_cnt + 16'h1;
         end
         next_q.locked = next_q.good_cnt >= q.regs[`DRML_I_LINT] &&
                         q.regs[`DRML_I_LINT] != 16'h0;
      end

      // Loop settings toward the filter core
      next_q.corner = bw[3:0];
      next_q.slope  = q.regs[`DRML_I_SLOPE];
      // Limiter is skipped by bypass or fast lock only
      next_q.bypass = bw[`DRML_B_BYP] | bw[`DRML_B_FAST];
      next_q.semi   = ctrl[`DRML_B_SEMI];
      // Core captures phase so a switch adds no step
      next_q.hold   = ref_switch & ~next_q.realign;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= rst_val();
      end else begin
         q <= next_q;
      end
   end

   assign s_axi_awready         = q.awr;
   assign s_axi_wready          = q.wr;
   assign s_axi_bvalid          = q.bv;
   assign s_axi_bresp           = q.bresp;
   assign s_axi_arready         = q.arr;
   assign s_axi_rvalid          = q.rv;
   assign s_axi_rdata           = {16'h0, q.rd};
   assign s_axi_rresp           = q.rresp;
   assign locked                = q.locked;
   assign corner_freq_select    = q.corner;
   assign slope_limit_setting   = q.slope;
   assign slope_limiter_bypass  = q.bypass;
   assign semi_fast_lock_enable = q.semi;
   assign phase_realign_request = q.realign;
   assign phase_hold            = q.hold;
   assign ref_fail              = q.fail;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence quiet_run;
      q.good_cnt >= q.regs[`DRML_I_LINT] && q.regs[`DRML_I_LINT] != 16'h0;
   endsequence
   sequence rcs_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == `DRML_I_RCS;
   endsequence

   a_lock_rise_ok: assert property ($rose(locked) |-> quiet_run)
      else $error("lock without quiet intervals");
   a_lock_int_len: assert property (q.li_cnt < 32'(LOCK_CYC))
      else $error("interval counter overran");
   a_lock_read_bit: assert property (rcs_read |=> s_axi_rdata[0] == $past(locked))
      else $error("lock status read wrong");
   a_bw_reset_val: assert property ($fell(reset) |-> corner_freq_select == `DRML_BW_DEF)
      else $error("corner select not at default");
   a_realign_one: assert property (phase_realign_request |=> !phase_realign_request)
      else $error("realign longer than one cycle");
   a_bypass_follow: assert property (bw[`DRML_B_BYP] [*2] |-> slope_limiter_bypass)
      else $error("bypass not applied");
   a_semi_limited: assert property ((bw[14:13] == 2'h0) [*2] |-> !slope_limiter_bypass)
      else $error("limiter bypassed without request");
   a_mask_hides: assert property ((mask[0] && mask[4]) [*2] |-> !ref_fail[0])
      else $error("masked reference still fails");
   a_mp_twice: assert property ($rose(q.mp_fail[0]) |-> $past(q.mp_prev[0]) == drml_pkg::ZN_BAD)
      else $error("multi-period fail on one measurement");
endmodule

// [include/drml_params.svh]
/*
 Constants of the reference monitor and lock supervisor.
 Assumes a 50 MHz clk; limits are kept in 10 ns units.
*/
`ifndef DRML_PARAMS_SVH
`define DRML_PARAMS_SVH
`define DRML_CLK_MHZ    50
`define DRML_LOCK_US    4000
`define DRML_UNIT_STEP  32'h2
`define DRML_N_REG      6'h30
`define DRML_I_CTRL     6'h00
`define DRML_I_BW       6'h01
`define DRML_I_RCC      6'h02
`define DRML_I_RCS      6'h03
`define DRML_I_LTHR     6'h04
`define DRML_I_LINT     6'h05
`define DRML_I_SLOPE    6'h06
`define DRML_I_MSTAT    6'h07
`define DRML_I_MASK     6'h08
`define DRML_I_FREQ     6'h09
`define DRML_I_NUL      6'h0A
`define DRML_I_FUL      6'h0C
`define DRML_I_NLL      6'h0E
`define DRML_I_FLL      6'h10
`define DRML_I_REF0     6'h20
`define DRML_B_OVR      1
`define DRML_B_PROG     2
`define DRML_B_SEMI     5
`define DRML_B_REAL     7
`define DRML_B_BYP      13
`define DRML_B_FAST     14
`define DRML_BW_DEF     4'h2
`define DRML_SLOPE_DEF  16'h0038
`define DRML_LTHR_DEF   16'h0040
`define DRML_LINT_DEF   16'h0004
`define DRML_MP_FU      32'h3B9A9DE8
`define DRML_MP_NU      32'h3B9AA346
`define DRML_MP_NOM     32'h3B9AC9FF
`define DRML_MP_NL      32'h3B9AF0B8
`define DRML_MP_FL      32'h3B9AF616
`define DRML_CNT_8K     32'h00013880
`define DRML_CNT_T1     32'h00EB9880
`define DRML_CNT_E1     32'h01388000
`define DRML_CNT_4M     32'h02710000
`define DRML_CNT_8M     32'h04E20000
`define DRML_CNT_16M    32'h09C40000
`define DRML_CNT_19M    32'h0B958F00
`define DRML_DET_8K     16'h0BB8
`define DRML_DET_T1     16'h001C
`define DRML_DET_E1     16'h0012
`define DRML_DET_4M     16'h0009
`define DRML_DET_8M     16'h0005
`define DRML_DET_16M    16'h0003
`define DRML_SPMAX_8K   16'h335C
`define DRML_SPMAX_T1   16'h0055
`define DRML_SPMAX_E1   16'h003B
`define DRML_SPMAX_4M   16'h001E
`define DRML_SPMAX_8M   16'h000F
`define DRML_SPMAX_16M  16'h0008
`define DRML_SPMAX_19M  16'h0007
`define DRML_SPMIN_8K   16'h2E4A
`define DRML_SPMIN_T1   16'h002B
`define DRML_SPMIN_E1   16'h0025
`define DRML_SPMIN_4M   16'h0011
`define DRML_SPMIN_8M   16'h0007
`define DRML_SPMIN_FAST 16'h0002
`endif

// [include/drml_pkg.sv]
/*
 Types of the reference monitor and lock supervisor.
 Assumes drml_params.svh for the numeric constants.
*/
package drml_pkg;
   typedef enum logic [2:0] {
      FR_8K  = 3'h0,
      FR_T1  = 3'h1,
      FR_E1  = 3'h2,
      FR_4M  = 3'h3,
      FR_8M  = 3'h4,
      FR_16M = 3'h5,
      FR_19M = 3'h6
   } drml_freq_e;
   typedef enum logic [2:0] {
      ZN_GOOD = 3'h1,
      ZN_GREY = 3'h2,
      ZN_BAD  = 3'h4
   } drml_zone_e;
   typedef struct packed {
      logic [47:0][15:0] regs;
      logic              awr, wr, arr, awh, wh, awok, bv, rv;
      logic [5:0]        awa;
      logic [15:0]       wd;
      logic [1:0]        ws, bresp, rresp;
      logic [15:0]       rd;
      logic [3:0]        s1, s2, s3;
      logic [3:0][15:0]  sp_cnt;
      logic [3:0]        sp_fail, mp_fail;
      logic [3:0][2:0]   det, mp_prev;
      logic [3:0][31:0]  mp_edges, mp_acc;
      logic [31:0]       li_cnt;
      logic              li_bad, locked;
      logic [15:0]       good_cnt, slope;
      logic [3:0]        corner, fail;
      logic              bypass, semi, realign, hold;
   } drml_state_s;
endpackage

// [verif/drml_ref_src.sv]
/*
 Four reference clock sources at 2.048 MHz.
 Assumes run is driven by the bench; a stopped source sits low.
*/
`timescale 1ns/1ps
module drml_ref_src #(
   parameter real HALF_NS = 244.140625
) (
   input  wire logic [3:0] run,
   output wire logic [3:0] ref_out
);
   genvar i;
   for (i = 0; i < 4; i++) begin : g_src
      logic level;
      assign ref_out[i] = level;
      // Staggered start keeps edges off the clk grid
      initial begin
         level = 1'h0;
         #(3.7 * (i + 1));
         forever begin
            level = run[i] ? ~level : 1'h0;
            #(HALF_NS);
         end
      end
   end
endmodule

// [verif/tb_top.sv]
/*
 Self-checking bench for the lock supervisor and reference monitors.
 Assumes drml_top, drml_ref_src and a 50 MHz clk; LOCK_CYC is cut to 20.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end
module tb_top;
   logic        clk;
   logic        reset;
   logic [3:0]  ref_in;
   logic [3:0]  ref_run;
   logic [15:0] phase_err_mag;
   logic        ref_switch;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, data;
   logic [3:0]  wstrb, corner, ref_fail;
   logic [1:0]  bresp, rresp, resp;
   logic [15:0] slope;
   logic        locked, bypass, semi, realign, hold;
   int          checks = 0;
   int          num_errors = 0;
   int          n_realign = 0;
   int          n_hold = 0;

   drml_top #(.LOCK_CYC(20)) dut_u (
      .clk                   (clk),
      .reset                 (reset),
      .ref_in                (ref_in),
      .phase_err_mag         (phase_err_mag),
      .ref_switch            (ref_switch),
      .s_axi_awvalid         (awvalid),
      .s_axi_awready         (awready),
      .s_axi_awaddr          (awaddr),
      .s_axi_wvalid          (wvalid),
      .s_axi_wready          (wready),
      .s_axi_wdata           (wdata),
      .s_axi_wstrb           (wstrb),
      .s_axi_bvalid          (bvalid),
      .s_axi_bready          (bready),
      .s_axi_bresp           (bresp),
      .s_axi_arvalid         (arvalid),
      .s_axi_arready         (arready),
      .s_axi_araddr          (araddr),
      .s_axi_rvalid          (rvalid),
      .s_axi_rready          (rready),
      .s_axi_rdata           (rdata),
      .s_axi_rresp           (rresp),
      .locked                (locked),
      .corner_freq_select    (corner),
      .slope_limit_setting   (slope),
      .slope_limiter_bypass  (bypass),
      .semi_fast_lock_enable (semi),
      .phase_realign_request (realign),
      .phase_hold            (hold),
      .ref_fail              (ref_fail)
   );
   drml_ref_src src_u (
      .run     (ref_run),
      .ref_out (ref_in)
   );

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   // Pulse counters, so pulse width and count are judged together
   always @(posedge clk) begin
      if (realign === 1'h1)
         n_realign++;
      if (hold === 1'h1)
         n_hold++;
   end

   task automatic conclude;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic hang;
      num_errors++;
      conclude();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bvalid && bready)
            break;
      end
      resp = bresp;
      bready <= 1'h0;
      if (n == 100)
         hang();
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rvalid && rready)
            break;
      end
      data = rdata;
      resp = rresp;
      rready <= 1'h0;
      if (n == 100)
         hang();
   endtask

   function automatic logic probe(int k);
      return (k == 0) ? locked : ref_fail[k - 1];
   endfunction

   // Bounded wait on locked (k 0) or one ref_fail bit (k 1..4)
   task automatic wait_for(input int k, input logic v, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge clk);
         if (probe(k) === v)
            break;
      end
      if (n == lim)
         hang();
   endtask

   task automatic t_reset;
      logic [7:0]  adr [4] = '{8'h04, 8'h18, 8'h10, 8'h14};
      logic [15:0] val [4] = '{16'h0002, 16'h0038, 16'h0040, 16'h0004};
      `CHK(corner, 4'h2)
      `CHK(slope, 16'h0038)
      `CHK({locked, bypass, semi, realign, hold, ref_fail}, 9'h000)
      for (int i = 0; i < 4; i++) begin
         rd(adr[i]);
         `CHK(data, {16'h0000, val[i]})
      end
      // Unmapped space answers with a decode error
      rd(8'hC0);
      `CHK({resp, data}, {2'h3, 32'h0})
      wr(8'hC0, 32'h0000_FFFF);
      `CHK(resp, 2'h3)
   endtask

   task automatic t_bandwidth;
      logic [15:0] val [4] = '{16'h000F, 16'h2005, 16'h4000, 16'h0002};
      logic [4:0]  want [4] = '{5'h0F, 5'h15, 5'h10, 5'h02};
      // Freerun is never set, so fast lock stays legal
      for (int i = 0; i < 4; i++) begin
         wr(8'h04, {16'h0000, val[i]});
         repeat (2) @(posedge clk);
         `CHK({resp, bypass, corner}, {2'h0, want[i]})
      end
      wr(8'h00, 32'h0000_0020);
      repeat (2) @(posedge clk);
      `CHK({semi, bypass}, 2'h2)
      wr(8'h18, 32'h0000_00BA);
      rd(8'h18);
      `CHK({data[15:0], slope}, {2{16'h00BA}})
   endtask

   task automatic t_rearrange;
      int c;
      c = n_realign;
      wr(8'h08, 32'h0000_0080);
      repeat (3) @(posedge clk);
      `CHK(n_realign - c, 1)
      // Low bits are kept, the realign bit never reads back
      wr(8'h08, 32'h0000_00FF);
      rd(8'h08);
      `CHK({n_realign - c, data}, {32'h2, 32'h7F})
      c = n_hold;
      ref_switch <= 1'h1;
      @(posedge clk);
      ref_switch <= 1'h0;
      repeat (4) @(posedge clk);
      `CHK(n_hold - c, 1)
   endtask

   task automatic t_lock;
      wait_for(0, 1'h1, 600);
      rd(8'h0C);
      `CHK(data[0], 1'h1)
      // One cycle at the threshold spoils the whole interval
      phase_err_mag <= 16'h0040;
      @(posedge clk);
      phase_err_mag <= 16'h0000;
      wait_for(0, 1'h0, 60);
      `CHK(locked, 1'h0)
      wr(8'h10, 32'h0000_0100);
      wr(8'h14, 32'h0000_0001);
      phase_err_mag <= 16'h00FF;
      wait_for(0, 1'h1, 100);
      `CHK(locked, 1'h1)
      phase_err_mag <= 16'h0100;
      wait_for(0, 1'h0, 60);
      `CHK(locked, 1'h0)
      phase_err_mag <= 16'h0000;
   endtask

   task automatic t_monitor;
      wr(8'h00, 32'h0000_0002);
      wr(8'h24, 32'h0000_0492);
      repeat (100) @(posedge clk);
      `CHK(ref_fail, 4'h0)
      ref_run <= 4'hE;
      wait_for(1, 1'h1, 200);
      rd(8'h1C);
      `CHK({data[11:0], ref_fail}, 16'h1011)
      ref_run <= 4'hF;
      wait_for(1, 1'h0, 400);
      wr(8'h20, 32'h0000_0002);
      ref_run <= 4'hD;
      repeat (200) @(posedge clk);
      rd(8'h1C);
      `CHK({data[3:0], ref_fail}, 8'h00)
      // Multi-period stays masked: its time base is far beyond this run
      wr(8'h20, 32'h0000_00F0);
      wait_for(2, 1'h1, 50);
      `CHK(ref_fail, 4'h2)
      ref_run <= 4'hF;
      wait_for(2, 1'h0, 400);
      wr(8'h80, 32'h0000_0028);
      wr(8'h84, 32'h0000_0010);
      wr(8'h00, 32'h0000_0006);
      wait_for(1, 1'h1, 200);
      `CHK(ref_fail[0], 1'h1)
      wr(8'h00, 32'h0000_0002);
      wait_for(1, 1'h0, 400);
      repeat (50) @(posedge clk);
      `CHK(ref_fail, 4'h0)
   endtask

   // Ten reference periods against small programmed limits
   task automatic t_multi;
      logic [7:0]  adr [11] = '{8'h20, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C,
                                8'h40, 8'h44, 8'h88, 8'h8C};
      logic [15:0] val [11] = '{16'h00EF, 16'h01D0, 16'h0000, 16'h01C0, 16'h0000, 16'h0200,
                                16'h0000, 16'h0210, 16'h0000, 16'h000A, 16'h0000};
      for (int i = 0; i < 11; i++) begin
         wr(adr[i], {16'h0000, val[i]});
      end
      wr(8'h00, 32'h0000_0006);
      repeat (1000) @(posedge clk);
      `CHK(ref_fail[0], 1'h0)
      ref_run <= 4'hE;
      repeat (250) @(posedge clk);
      `CHK(ref_fail[0], 1'h0)
      wait_for(1, 1'h1, 400);
      rd(8'h1C);
      `CHK(data[11:0], 12'h110)
      // Near upper above the nominal length leaves it grey
      wr(8'h28, 32'h0000_01F0);
      ref_run <= 4'hF;
      repeat (800) @(posedge clk);
      `CHK(ref_fail[0], 1'h1)
      wr(8'h28, 32'h0000_01D0);
      wait_for(1, 1'h0, 1200);
      `CHK(ref_fail[0], 1'h0)
   endtask

   initial begin
      reset         = 1'h1;
      ref_run       = 4'hF;
      phase_err_mag = 16'h0000;
      ref_switch    = 1'h0;
      awvalid       = 1'h0;
      wvalid        = 1'h0;
      bready        = 1'h0;
      arvalid       = 1'h0;
      rready        = 1'h0;
      awaddr        = 8'h00;
      araddr        = 8'h00;
      wdata         = 32'h0;
      wstrb         = 4'hF;
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      t_reset();
      t_bandwidth();
      t_rearrange();
      t_lock();
      t_monitor();
      t_multi();
      conclude();
   end
endmodule
